/* File: include/crh_pkg.sv */
// Shared constants and types of the counter readout command handler.
`default_nettype none
package crh_pkg;

	localparam int CRH_DW = 32;
	localparam int CRH_AW = 8;
	localparam int CRH_GW = 7;

	// Register byte offsets.
	localparam logic [7:0] CRH_CTRL_OFS = 8'h00;
	localparam logic [7:0] CRH_CMD_OFS = 8'h04;
	localparam logic [7:0] CRH_STATUS_OFS = 8'h08;
	localparam logic [7:0] CRH_RESULT_OFS = 8'h0c;
	localparam logic [7:0] CRH_ERROR_OFS = 8'h10;
	localparam logic [7:0] CRH_AVGCNT_OFS = 8'h14;
	localparam logic [7:0] CRH_FUNC_OFS = 8'h18;
	localparam logic [7:0] CRH_IRQ_ST_OFS = 8'h1c;
	localparam logic [7:0] CRH_IRQ_MASK_OFS = 8'h20;
	localparam logic [7:0] CRH_RES_OFS = 8'h24;

	// Field positions.
	localparam int CRH_CTRL_TBOUT = 0;
	localparam int CRH_CTRL_AVG = 1;
	localparam int CRH_CTRL_CONT = 2;
	localparam int CRH_CMD_OP_LSB = 0;
	localparam int CRH_CMD_IN_LSB = 4;
	localparam int CRH_CMD_FN_LSB = 8;
	localparam int CRH_ST_ROUTED = 0;
	localparam int CRH_ST_AVG = 1;
	localparam int CRH_ST_BUSY = 2;
	localparam int CRH_ST_VALID = 3;
	localparam int CRH_ST_CONT = 4;
	localparam int CRH_IRQ_DONE = 0;
	localparam int CRH_IRQ_ERR = 1;

	// Gate counts and the resolution threshold for automatic averaging.
	localparam logic [6:0] CRH_AVG_GATES = 7'h64;
	localparam logic [6:0] CRH_SINGLE_GATE = 7'h01;
	localparam logic [31:0] CRH_FINE_RES_NS = 32'h1;
	localparam logic [31:0] CRH_PS_PER_NS = 32'h3e8;
	localparam logic [31:0] CRH_FINE_RES_PS = 32'(CRH_FINE_RES_NS * CRH_PS_PER_NS);

	// Error codes as two's complement words.
	localparam logic [31:0] CRH_ERR_NOCONF = 32'hffffff34;
	localparam logic [31:0] CRH_ERR_INIT_IGN = 32'hffffff2b;
	localparam logic [31:0] CRH_ERR_SETTINGS = 32'hffffff23;

	typedef enum logic [2:0] {
		CRH_OP_NOP = 3'b000,
		CRH_OP_READ = 3'b001,
		CRH_OP_CONF = 3'b010,
		CRH_OP_MEAS = 3'b011,
		CRH_OP_ABORT = 3'b100,
		CRH_OP_INIT = 3'b101,
		CRH_OP_FETCH = 3'b110
	} crh_op_t;

	typedef enum logic [3:0] {
		CRH_FN_NONE = 4'b0000,
		CRH_FN_FREQ = 4'b0001,
		CRH_FN_FREQUENCY_RATIO = 4'b0010,
		CRH_FN_PERIOD = 4'b0011,
		CRH_FN_TIME_BETWEEN_EDGES = 4'b0100,
		CRH_FN_TOTALIZE = 4'b0101,
		CRH_FN_RISE = 4'b0110,
		CRH_FN_FALL = 4'b0111,
		CRH_FN_PWIDTH = 4'b1000,
		CRH_FN_NWIDTH = 4'b1001
	} crh_func_t;

endpackage : crh_pkg
`default_nettype wire

/* File: rtl/crh_avg.sv */
// Gate sequencer that sums one or more gate results into one reading.
`timescale 1ns/1ps
`default_nettype none
module crh_avg
	import crh_pkg::*;
#(
	parameter int DW = 32,
	parameter int GW = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic start,
	input wire logic abort,
	input wire logic [GW-1:0] gates,
	input wire logic gate_done,
	input wire logic [DW-1:0] gate_value,
	output logic gate_start,
	output logic done,
	output logic [DW-1:0] sum
);

	typedef struct packed {
		logic active;
		logic [GW-1:0] left;
		logic [DW-1:0] acc;
		logic gate_start;
		logic done;
	} crh_avg_state_t;

	crh_avg_state_t s;
	crh_avg_state_t n;

	always_comb begin
		n = s;
		n.gate_start = 1'b0;
		n.done = 1'b0;
		if (start) begin
			n.active = 1'b1;
			n.left = gates;
			n.acc = '0;
			n.gate_start = 1'b1;
		end else if (abort) begin
			n.active = 1'b0;
		end else if (s.active && gate_done) begin
			n.acc = s.acc + gate_value;
			n.left = s.left - 1'b1;
			if (s.left == 1'b1) begin
				n.active = 1'b0;
				n.done = 1'b1;
			end else begin
				n.gate_start = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign gate_start = s.gate_start;
	assign done = s.done;
	assign sum = s.acc;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	last_gate_done_a: assert property (
		ce && !start && !abort && s.active && gate_done && s.left == 1'b1
		|=> done && !s.active)
		else $error("Last gate did not complete the reading.");

	single_gate_a: assert property (
		ce && start && gates == 1'b1 ##1 ce && !start && !abort && gate_done
		|=> done)
		else $error("Single-shot reading took more than one gate.");

endmodule : crh_avg
`default_nettype wire

/* File: rtl/crh_top.sv */
// Remote command handler for reference output, readout and gate averaging.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module crh_top
	import crh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CRH_AW-1:0] paddr,
	input wire logic [CRH_DW-1:0] pwdata,
	output logic [CRH_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic tb_in,
	output logic ref_out,
	output logic ref_out_en,
	output logic gate_start,
	output logic [1:0] gate_input,
	output logic [3:0] gate_func,
	input wire logic gate_done,
	input wire logic [CRH_DW-1:0] gate_value
);

	typedef struct packed {
		logic tb_en;
		logic avg_on;
		logic cont;
		logic tb_s1;
		logic tb_s2;
		logic ref_on;
		logic ref_en;
		crh_func_t [2:0] funcs;
		logic [CRH_DW-1:0] res_ps;
		logic [CRH_DW-1:0] err;
		logic [1:0] irq_st;
		logic [1:0] irq_mask;
		logic busy;
		logic fetch_pend;
		logic have_res;
		logic [1:0] cur_in;
		crh_func_t cur_func;
		logic [CRH_DW-1:0] meas_res;
		logic [CRH_DW-1:0] out_buf;
		logic out_valid;
		logic avg_start;
		logic avg_abort;
		logic [CRH_DW-1:0] prdata;
	} crh_state_t;

	crh_state_t s;
	crh_state_t n;

	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic wr_cmd;
	logic addr_ok;
	logic [CRH_DW-1:0] rd_data;
	crh_op_t cmd_op;
	crh_func_t cmd_fn;
	logic [1:0] cmd_in;
	logic [1:0] cmd_idx;
	logic in3_ok;
	logic fine_res;
	crh_func_t cfg_func;
	logic [CRH_GW-1:0] gates;
	logic avg_done;
	logic [CRH_DW-1:0] avg_sum;
	logic err_ev;
	logic do_read;
	logic go;
	logic [1:0] go_idx;
	logic [1:0] w1c;

	////////////////////////////////////////////////////////////////////////
	// APB decode. Every access completes in its first access cycle.

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign wr_cmd = wr_acc && paddr == CRH_CMD_OFS;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = s.prdata;

	always_comb begin
		case (paddr)
			CRH_CTRL_OFS, CRH_CMD_OFS, CRH_STATUS_OFS, CRH_RESULT_OFS,
			CRH_ERROR_OFS, CRH_AVGCNT_OFS, CRH_FUNC_OFS, CRH_IRQ_ST_OFS,
			CRH_IRQ_MASK_OFS, CRH_RES_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_comb begin
		rd_data = '0;
		case (paddr)
			CRH_CTRL_OFS: begin
				rd_data[CRH_CTRL_TBOUT] = s.tb_en;
				rd_data[CRH_CTRL_AVG] = s.avg_on;
				rd_data[CRH_CTRL_CONT] = s.cont;
			end
			CRH_STATUS_OFS: begin
				rd_data[CRH_ST_ROUTED] = s.ref_en;
				rd_data[CRH_ST_AVG] = s.avg_on;
				rd_data[CRH_ST_BUSY] = s.busy;
				rd_data[CRH_ST_VALID] = s.out_valid;
				rd_data[CRH_ST_CONT] = s.cont;
			end
			CRH_RESULT_OFS: rd_data = s.out_buf;
			CRH_ERROR_OFS: rd_data = s.err;
			CRH_AVGCNT_OFS: rd_data[CRH_GW-1:0] = CRH_AVG_GATES;
			CRH_FUNC_OFS: rd_data[11:0] = s.funcs;
			CRH_IRQ_ST_OFS: rd_data[1:0] = s.irq_st;
			CRH_IRQ_MASK_OFS: rd_data[1:0] = s.irq_mask;
			CRH_RES_OFS: rd_data = s.res_ps;
			default: rd_data = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Command fields. An input field of zero means the default input.

	assign cmd_op = crh_op_t'(pwdata[CRH_CMD_OP_LSB +: 3]);
	assign cmd_fn = crh_func_t'(pwdata[CRH_CMD_FN_LSB +: 4]);
	assign cmd_in = pwdata[CRH_CMD_IN_LSB +: 2];
	assign cmd_idx = (cmd_in == 2'h0) ? 2'h0 : cmd_in - 2'h1;
	assign cfg_func = s.funcs[cmd_idx];
	assign in3_ok = cmd_fn == CRH_FN_FREQ ||
		cmd_fn == CRH_FN_FREQUENCY_RATIO || cmd_fn == CRH_FN_PERIOD;
	assign fine_res = s.res_ps != '0 && s.res_ps < CRH_FINE_RES_PS;
	assign gates = s.avg_on ? CRH_AVG_GATES : CRH_SINGLE_GATE;
	assign w1c = (wr_acc && paddr == CRH_IRQ_ST_OFS) ? pwdata[1:0] : 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		n = s;
		err_ev = 1'b0;
		do_read = 1'b0;
		go = 1'b0;
		go_idx = cmd_idx;
		n.avg_start = 1'b0;
		n.avg_abort = 1'b0;
		n.tb_s1 = tb_in;
		n.tb_s2 = s.tb_s1;
		n.ref_on = s.tb_en && s.tb_s2;
		n.ref_en = s.tb_en;
		if (setup) begin
			n.prdata = rd_data;
		end
		if (rd_acc && paddr == CRH_RESULT_OFS) begin
			n.out_valid = 1'b0;
		end
		if (wr_acc) begin
			case (paddr)
				CRH_CTRL_OFS: begin
					n.tb_en = pwdata[CRH_CTRL_TBOUT];
					n.avg_on = pwdata[CRH_CTRL_AVG];
					n.cont = pwdata[CRH_CTRL_CONT];
				end
				CRH_RES_OFS: n.res_ps = pwdata;
				CRH_IRQ_MASK_OFS: n.irq_mask = pwdata[1:0];
				default: ;
			endcase
		end
		if (avg_done && s.busy) begin
			n.busy = 1'b0;
			n.meas_res = avg_sum;
			n.have_res = 1'b1;
			if (s.fetch_pend) begin
				n.out_buf = avg_sum;
				n.out_valid = 1'b1;
				n.fetch_pend = 1'b0;
			end
		end
		if (wr_cmd) begin
			case (cmd_op)
				CRH_OP_CONF, CRH_OP_MEAS: begin
					if (cmd_idx == 2'h2 && !in3_ok) begin
						n.err = CRH_ERR_SETTINGS;
						err_ev = 1'b1;
					end else begin
						n.funcs[cmd_idx] = cmd_fn;
						if (fine_res) begin
							n.avg_on = 1'b1;
						end
						do_read = cmd_op == CRH_OP_MEAS;
					end
				end
				CRH_OP_READ: do_read = 1'b1;
				CRH_OP_ABORT: begin
					n.avg_abort = 1'b1;
					n.busy = 1'b0;
					n.fetch_pend = 1'b0;
				end
				CRH_OP_INIT: begin
					if (n.funcs[cmd_idx] == CRH_FN_NONE) begin
						n.err = CRH_ERR_NOCONF;
						err_ev = 1'b1;
					end else begin
						go = 1'b1;
					end
				end
				CRH_OP_FETCH: begin
					if (n.have_res) begin
						n.out_buf = n.meas_res;
						n.out_valid = 1'b1;
					end else if (n.busy) begin
						n.fetch_pend = 1'b1;
					end
				end
				default: ;
			endcase
			if (do_read) begin
				if (s.cont) begin
					n.err = CRH_ERR_INIT_IGN;
					err_ev = 1'b1;
				end else if (n.funcs[cmd_idx] == CRH_FN_NONE) begin
					n.err = CRH_ERR_NOCONF;
					err_ev = 1'b1;
				end else begin
					// Restart replaces any running measurement.
					go = 1'b1;
					n.fetch_pend = 1'b1;
				end
			end
		end
		if (!go && n.cont && !n.busy && n.funcs[s.cur_in] != CRH_FN_NONE) begin
			go = 1'b1;
			go_idx = s.cur_in;
		end
		if (go) begin
			n.avg_start = 1'b1;
			n.busy = 1'b1;
			n.have_res = 1'b0;
			n.cur_in = go_idx;
			n.cur_func = n.funcs[go_idx];
		end
		// A new event wins over a clear in the same cycle.
		n.irq_st = (s.irq_st & ~w1c) | {err_ev, avg_done && s.busy};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	crh_avg #(
		.DW(CRH_DW),
		.GW(CRH_GW)
	) u_avg (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.start(s.avg_start),
		.abort(s.avg_abort),
		.gates(gates),
		.gate_done(gate_done),
		.gate_value(gate_value),
		.gate_start(gate_start),
		.done(avg_done),
		.sum(avg_sum)
	);

	assign ref_out = s.ref_on;
	assign ref_out_en = s.ref_en;
	assign gate_input = s.cur_in + 2'h1;
	assign gate_func = s.cur_func;
	assign irq = |(s.irq_st & s.irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence read_cmd_s;
		ce && wr_cmd && cmd_op == CRH_OP_READ;
	endsequence

	sequence read_go_s;
		read_cmd_s ##0 !s.cont && cfg_func != CRH_FN_NONE;
	endsequence

	ref_disable_a: assert property (
		ce && !s.tb_en |=> !ref_out_en && !ref_out)
		else $error("Reference output stayed enabled after switch-off.");

	route_status_a: assert property (
		ce && setup && paddr == CRH_STATUS_OFS
		|=> prdata[CRH_ST_ROUTED] == $past(ref_out_en))
		else $error("Routing status does not match the output enable.");

	read_starts_a: assert property (
		read_go_s |=> s.avg_start && s.busy && s.fetch_pend)
		else $error("Read did not start a fetching measurement.");

	default_input_a: assert property (
		read_go_s ##0 cmd_in == 2'h0 |=> gate_input == 2'h1)
		else $error("Read without input did not select input 1.");

	func_ignored_a: assert property (
		read_go_s |=> gate_func == $past(cfg_func))
		else $error("Read did not measure the configured function.");

	noconf_err_a: assert property (
		read_cmd_s ##0 !s.cont && cfg_func == CRH_FN_NONE
		|=> s.err == CRH_ERR_NOCONF && !s.avg_start)
		else $error("Unconfigured read did not report -204.");

	cont_reject_a: assert property (
		read_cmd_s ##0 s.cont |=> s.err == CRH_ERR_INIT_IGN && !s.fetch_pend)
		else $error("Read in continuous mode was not rejected.");

	avg_gates_a: assert property (
		s.avg_start && s.avg_on |-> gates == 7'h64)
		else $error("Averaged reading not set to one hundred gates.");

	fine_res_a: assert property (
		ce && wr_cmd && cmd_op == CRH_OP_CONF && cmd_idx != 2'h2 && fine_res
		|=> s.avg_on)
		else $error("Fine resolution did not switch averaging on.");

	input3_guard_a: assert property (
		ce && wr_cmd && cmd_op == CRH_OP_CONF && cmd_idx == 2'h2 && !in3_ok
		|=> $stable(s.funcs) && s.err == CRH_ERR_SETTINGS)
		else $error("Input 3 accepted a forbidden function.");

	avg_count_a: assert property (
		ce && setup && paddr == CRH_AVGCNT_OFS |=> prdata == 32'h64)
		else $error("Averaging count did not read as one hundred.");

	bool_query_a: assert property (
		ce && setup && paddr == CRH_CTRL_OFS
		|=> prdata[2:0] == $past({s.cont, s.avg_on, s.tb_en}))
		else $error("Boolean settings did not read back as 1 or 0.");

endmodule : crh_top
`default_nettype wire

/* File: dv/crh_core_model.sv */
// Behavioural measurement core that answers each gate request of the handler.
`timescale 1ns/1ps
`default_nettype none
module crh_core_model
	import crh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic gate_start,
	input wire logic [1:0] gate_input,
	input wire logic [3:0] gate_func,
	output logic gate_done,
	output logic [CRH_DW-1:0] gate_value
);
	logic pend;
	logic [1:0] cnt;
	// Outside a done pulse the value toggles so a stale read cannot match.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 1'b0;
			cnt <= 2'h0;
			gate_done <= 1'b0;
			gate_value <= 32'h0;
		end else begin
			gate_done <= 1'b0;
			gate_value <= ~gate_value;
			if (gate_start) begin
				pend <= 1'b1;
				cnt <= slow ? 2'h3 : 2'h0;
			end else if (pend && cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end else if (pend) begin
				pend <= 1'b0;
				gate_done <= 1'b1;
				gate_value <= 32'h100 * gate_func + 32'(gate_input);
			end
		end
	end
endmodule : crh_core_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench of the counter readout command handler.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
 $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module testbench;
	import crh_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic tb_in = 0, slow = 0, ce = 1, err, pready, pslverr, irq, ref_out;
	logic ref_out_en, gate_start, gate_done;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, r = 32'h526285c8, prdata, gate_value;
	logic [1:0] gate_input, in, ein;
	logic [3:0] gate_func, fn;
	logic [3:0] fcfg [1:3];
	logic [3:0] fns [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
	int miscompares = 0, checks_done = 0, gcnt = 0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) if (gate_start === 1'b1) gcnt++;
	crh_top dut(.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.tb_in(tb_in), .ref_out(ref_out), .ref_out_en(ref_out_en),
		.gate_start(gate_start), .gate_input(gate_input),
		.gate_func(gate_func), .gate_done(gate_done),
		.gate_value(gate_value));
	crh_core_model core(.pclk(pclk), .presetn(presetn), .slow(slow),
		.gate_start(gate_start), .gate_input(gate_input),
		.gate_func(gate_func), .gate_done(gate_done),
		.gate_value(gate_value));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] cmd(input logic [2:0] op,
		input logic [1:0] i, input logic [3:0] f);
		return {20'h0, f, 2'b00, i, 1'b0, op};
	endfunction : cmd
	// A reading is the sum of identical gate values, one per gate.
	function automatic logic [31:0] esum(input int n, input logic [1:0] i,
		input logic [3:0] f);
		return 32'(n) * (32'h100 * f + 32'(i));
	endfunction : esum
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			miscompares++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdc
	// Polls one status bit; the poll count bounds the wait.
	task automatic wait_st(input int b, input logic v);
		int i;
		for (i = 0; i < 400; i++) begin
			bus(1'b0, CRH_STATUS_OFS, 32'h0);
			if (rd[b] === v) break;
		end
		if (i == 400) begin
			miscompares++;
			test_done();
		end
	endtask : wait_st
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone
	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		test_done();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(CRH_CTRL_OFS, 32'h0);
		rdc(CRH_STATUS_OFS, 32'h0);
		`CHK(ref_out_en, 1'b0)
		wr(CRH_AVGCNT_OFS, 32'h0);
		rdc(CRH_AVGCNT_OFS, 32'h64);
		// A write while the clock enable is low must leave no trace.
		ce <= 1'b0;
		wr(CRH_CTRL_OFS, 32'h1);
		ce <= 1'b1;
		rdc(CRH_CTRL_OFS, 32'h0);
		bus(1'b0, 8'h3c, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		tdone("reset");
		tb_in <= 1'b1;
		wr(CRH_CTRL_OFS, 32'h1);
		repeat (4) @(posedge pclk);
		`CHK({ref_out_en, ref_out}, 2'b11)
		tb_in <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK({ref_out_en, ref_out}, 2'b10)
		tb_in <= 1'b1;
		rdc(CRH_STATUS_OFS, 32'h1);
		rdc(CRH_CTRL_OFS, 32'h1);
		wr(CRH_CTRL_OFS, 32'h0);
		repeat (4) @(posedge pclk);
		`CHK({ref_out_en, ref_out}, 2'b00)
		rdc(CRH_STATUS_OFS, 32'h0);
		tdone("timebase");
		gcnt = 0;
		wr(CRH_CMD_OFS, cmd(CRH_OP_READ, 2'h2, CRH_FN_FREQ));
		repeat (4) @(posedge pclk);
		rdc(CRH_ERROR_OFS, CRH_ERR_NOCONF);
		`CHK(gcnt, 0)
		rdc(CRH_IRQ_ST_OFS, 32'h2);
		wr(CRH_IRQ_ST_OFS, 32'h2);
		rdc(CRH_IRQ_ST_OFS, 32'h0);
		tdone("unconfigured");
		// Back-to-back configure and read; the read names a foreign function.
		for (int k = 0; k < 4; k++) begin
			r = lfsr(r);
			fn = fns[r[2:0]];
			in = (k > 0 && r[3]) ? 2'h2 : 2'h0;
			ein = (in == 2'h0) ? 2'h1 : in;
			fcfg[ein] = fn;
			slow <= r[4];
			wr(CRH_CMD_OFS, cmd(CRH_OP_CONF, in, fn));
			gcnt = 0;
			wr(CRH_CMD_OFS, cmd(CRH_OP_READ, in, CRH_FN_TOTALIZE));
			wait_st(CRH_ST_VALID, 1'b1);
			`CHK(gate_input, ein)
			`CHK(gate_func, fn)
			rdc(CRH_RESULT_OFS, esum(1, ein, fn));
			`CHK(gcnt, 1)
			`CHK(irq, 1'b0)
		end
		wr(CRH_IRQ_MASK_OFS, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		wr(CRH_IRQ_ST_OFS, 32'h3);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		tdone("read");
		wr(CRH_CTRL_OFS, 32'h2);
		rdc(CRH_STATUS_OFS, 32'h2);
		gcnt = 0;
		slow <= 1'b1;
		wr(CRH_CMD_OFS, cmd(CRH_OP_READ, 2'h1, CRH_FN_NONE));
		wait_st(CRH_ST_VALID, 1'b1);
		`CHK(gcnt, 100)
		rdc(CRH_RESULT_OFS, esum(100, 2'h1, fcfg[1]));
		wr(CRH_CTRL_OFS, 32'h0);
		wr(CRH_RES_OFS, CRH_FINE_RES_PS);
		wr(CRH_CMD_OFS, cmd(CRH_OP_CONF, 2'h2, CRH_FN_PERIOD));
		repeat (2) @(posedge pclk);
		rdc(CRH_STATUS_OFS, 32'h0);
		wr(CRH_RES_OFS, CRH_FINE_RES_PS - 32'h1);
		gcnt = 0;
		wr(CRH_CMD_OFS, cmd(CRH_OP_MEAS, 2'h2, CRH_FN_PERIOD));
		wait_st(CRH_ST_VALID, 1'b1);
		`CHK(rd[CRH_ST_AVG], 1'b1)
		`CHK(gcnt, 100)
		rdc(CRH_RESULT_OFS, esum(100, 2'h2, CRH_FN_PERIOD));
		wr(CRH_CTRL_OFS, 32'h0);
		wr(CRH_RES_OFS, 32'h0);
		tdone("averaging");
		wr(CRH_CMD_OFS, cmd(CRH_OP_CONF, 2'h3, CRH_FN_TOTALIZE));
		rdc(CRH_ERROR_OFS, CRH_ERR_SETTINGS);
		bus(1'b0, CRH_FUNC_OFS, 32'h0);
		`CHK(rd[11:8], 4'h0)
		for (int k = 1; k < 4; k++) begin
			wr(CRH_CMD_OFS, cmd(CRH_OP_CONF, 2'h3, 4'(k)));
			bus(1'b0, CRH_FUNC_OFS, 32'h0);
			`CHK(rd[11:8], 4'(k))
		end
		tdone("input3");
		wr(CRH_CTRL_OFS, 32'h4);
		wr(CRH_CMD_OFS, cmd(CRH_OP_READ, 2'h1, CRH_FN_NONE));
		rdc(CRH_ERROR_OFS, CRH_ERR_INIT_IGN);
		wr(CRH_CTRL_OFS, 32'h0);
		wait_st(CRH_ST_BUSY, 1'b0);
		bus(1'b0, CRH_RESULT_OFS, 32'h0);
		tdone("continuous");
		// Totalize is collected with initiate and fetch, never with read.
		wr(CRH_CMD_OFS, cmd(CRH_OP_CONF, 2'h1, CRH_FN_TOTALIZE));
		gcnt = 0;
		wr(CRH_CMD_OFS, cmd(CRH_OP_INIT, 2'h1, CRH_FN_NONE));
		wr(CRH_CMD_OFS, cmd(CRH_OP_FETCH, 2'h1, CRH_FN_NONE));
		wait_st(CRH_ST_VALID, 1'b1);
		rdc(CRH_RESULT_OFS, esum(1, 2'h1, CRH_FN_TOTALIZE));
		`CHK(gcnt, 1)
		// An abort right after initiate leaves the handler idle, no result.
		wr(CRH_CMD_OFS, cmd(CRH_OP_INIT, 2'h1, CRH_FN_NONE));
		wr(CRH_CMD_OFS, cmd(CRH_OP_ABORT, 2'h1, CRH_FN_NONE));
		repeat (10) @(posedge pclk);
		rdc(CRH_STATUS_OFS, 32'h0);
		tdone("totalize");
		test_done();
	end
endmodule : testbench
`default_nettype wire
